/* File: initial_speed_brake_config.sv */
// Initial speed detect configuration word, threshold decode and brake sequencer
// How it works
// - Bits 24-22 pick the stationary back-EMF threshold of 5,10,15,20,25,30,50 or 100 mV.
// - Bit 21 low brakes on all three low-side switches, high on all three high-side ones.
// - Bit 20 low ends braking after the brake duration, high when phase current is below limit.
// - Bits 19-17 pick the brake exit current level of 5,10,15,20,25,30,50 or 100 mV.
// - Bits 16-13 pick the brake duration from 10 ms up to 15 s.
// - Bits 12-9 pick the high-impedance hold time from the same 10 ms to 15 s table.
// - Bits 8-6 pick the standstill brake time of 1,10,25,50,100,250,500 or 1000 ms.
// - Bits 5-3 codes 1 to 7 give the 300 to 1250 mV back-EMF level below which it coasts.
// - Code zero in bits 5-3 makes the coast level come from the minimum duty setting.
// - Bits 2-0 are reserved, read zero and do nothing.
// - A stationary motor is braked on a standstill request only when the standstill brake enable bit is set.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "isd_cfg.svh"
module initial_speed_brake_config
    import isd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `MS_TICK_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Analog measurements in mV and duty-derived coast level
    input  wire logic [10:0] phase_emf_mv_i,
    input  wire logic [10:0] phase_cur_mv_i,
    input  wire logic [10:0] min_duty_emf_mv_i,
    // Decoded levels and power stage control
    output logic      [10:0] stat_thr_mv_o,
    output logic      [10:0] brk_cur_mv_o,
    output logic      [10:0] resync_thr_mv_o,
    output logic             motor_stationary_o,
    output logic             coast_not_resync_o,
    output logic             low_side_on_o,
    output logic             high_side_on_o,
    output logic             outputs_hiz_o,
    output logic             busy_o
);
    isd_tick_if tk ();

    isd_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .tk    (tk)
    );

    function automatic logic [10:0] mv8(input logic [2:0] c);
        case (c)
            3'h0:    mv8 = 11'd5;
            3'h1:    mv8 = 11'd10;
            3'h2:    mv8 = 11'd15;
            3'h3:    mv8 = 11'd20;
            3'h4:    mv8 = 11'd25;
            3'h5:    mv8 = 11'd30;
            3'h6:    mv8 = 11'd50;
            default: mv8 = 11'd100;
        endcase
    endfunction : mv8

    function automatic ms_t long_ms(input logic [3:0] c);
        case (c)
            4'h0:    long_ms = 14'd10;
            4'h1:    long_ms = 14'd50;
            4'h2:    long_ms = 14'd100;
            4'h3:    long_ms = 14'd200;
            4'h4:    long_ms = 14'd300;
            4'h5:    long_ms = 14'd400;
            4'h6:    long_ms = 14'd500;
            4'h7:    long_ms = 14'd750;
            4'h8:    long_ms = 14'd1000;
            4'h9:    long_ms = 14'd2000;
            4'hA:    long_ms = 14'd3000;
            4'hB:    long_ms = 14'd4000;
            4'hC:    long_ms = 14'd5000;
            4'hD:    long_ms = 14'd7500;
            4'hE:    long_ms = 14'd10000;
            default: long_ms = 14'd15000;
        endcase
    endfunction : long_ms

    function automatic ms_t short_ms(input logic [2:0] c);
        case (c)
            3'h0:    short_ms = 14'd1;
            3'h1:    short_ms = 14'd10;
            3'h2:    short_ms = 14'd25;
            3'h3:    short_ms = 14'd50;
            3'h4:    short_ms = 14'd100;
            3'h5:    short_ms = 14'd250;
            3'h6:    short_ms = 14'd500;
            default: short_ms = 14'd1000;
        endcase
    endfunction : short_ms

    function automatic logic [10:0] resync_mv(input logic [2:0] c);
        case (c)
            3'h1:    resync_mv = 11'd300;
            3'h2:    resync_mv = 11'd400;
            3'h3:    resync_mv = 11'd500;
            3'h4:    resync_mv = 11'd600;
            3'h5:    resync_mv = 11'd800;
            3'h6:    resync_mv = 11'd1000;
            default: resync_mv = 11'd1250;
        endcase
    endfunction : resync_mv

    // Register file
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        ready_r;
    logic        ready_nxt;
    logic        err_r;
    logic        err_nxt;
    logic        start_nxt;
    logic        stat_req_nxt;

    wire logic acc  = psel_i && penable_i && !ready_r;
    // Writes land only at the edge where the master sees pready high
    wire logic wcom = psel_i && penable_i && ready_r && pwrite_i;

    always_comb begin
        cfg_nxt      = cfg_r;
        rdata_nxt    = rdata_r;
        ready_nxt    = acc;
        err_nxt      = 1'b0;
        start_nxt    = 1'b0;
        stat_req_nxt = 1'b0;
        if (wcom) begin
            if (paddr_i == `CFG_WORD_OFFSET) begin
                cfg_nxt = pwdata_i & `CFG_WORD_WMASK;
            end
            if (paddr_i == `ISD_CONTROL_OFFSET) begin
                start_nxt    = pwdata_i[`CTL_START_BIT];
                stat_req_nxt = pwdata_i[`CTL_STATIONARY_BIT];
            end
        end
        if (acc) begin
            rdata_nxt = 32'h00000000;
            case (paddr_i)
                `CFG_WORD_OFFSET: begin
                    if (!pwrite_i) begin
                        rdata_nxt = cfg_r;
                    end
                end
                `ISD_CONTROL_OFFSET: begin
                    rdata_nxt = 32'h00000000;
                end
                `ISD_STATUS_OFFSET: begin
                    rdata_nxt = {26'h0000000, busy_o, outputs_hiz_o, high_side_on_o,
                                 low_side_on_o, coast_not_resync_o, motor_stationary_o};
                end
                default: err_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r   <= `CFG_WORD_RESET;
            rdata_r <= 32'h00000000;
            ready_r <= 1'b0;
            err_r   <= 1'b0;
        end else if (ce_i) begin
            cfg_r   <= cfg_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r   <= err_nxt;
        end
    end

    assign prdata_o  = rdata_r;
    assign pready_o  = ready_r;
    assign pslverr_o = err_r;

    // Threshold decode and comparisons
    logic [10:0] stat_thr_r;
    logic [10:0] brk_cur_r;
    logic [10:0] resync_r;
    logic        stat_r;
    logic        coast_r;
    logic [10:0] resync_sel;

    always_comb begin
        if (cfg_r[`RESYNC_HI:`RESYNC_LO] == 3'h0) begin
            resync_sel = min_duty_emf_mv_i;
        end else begin
            resync_sel = resync_mv(cfg_r[`RESYNC_HI:`RESYNC_LO]);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_thr_r <= 11'h000;
            brk_cur_r  <= 11'h000;
            resync_r   <= 11'h000;
            stat_r     <= 1'b0;
            coast_r    <= 1'b0;
        end else if (ce_i) begin
            stat_thr_r <= mv8(cfg_r[`STAT_THR_HI:`STAT_THR_LO]);
            brk_cur_r  <= mv8(cfg_r[`BRK_CUR_HI:`BRK_CUR_LO]);
            resync_r   <= resync_sel;
            stat_r     <= phase_emf_mv_i < mv8(cfg_r[`STAT_THR_HI:`STAT_THR_LO]);
            coast_r    <= phase_emf_mv_i < resync_sel;
        end
    end

    assign stat_thr_mv_o      = stat_thr_r;
    assign brk_cur_mv_o       = brk_cur_r;
    assign resync_thr_mv_o    = resync_r;
    assign motor_stationary_o = stat_r;
    assign coast_not_resync_o = coast_r;

    // Brake and high-impedance sequencer, started by a control write
    seq_state_e st_r;
    seq_state_e st_nxt;
    ms_t        ms_r;
    ms_t        ms_nxt;
    logic       lo_r;
    logic       lo_nxt;
    logic       hi_r;
    logic       hi_nxt;
    logic       hiz_r;
    logic       hiz_nxt;
    logic       busy_r;
    logic       busy_nxt;

    wire logic brake_done = cfg_r[`BRK_EXIT_BIT] ?
                            (phase_cur_mv_i < brk_cur_r) :
                            (tk.tick && ms_r <= 14'd1);

    always_comb begin
        st_nxt  = st_r;
        ms_nxt  = ms_r;
        lo_nxt  = 1'b0;
        hi_nxt  = 1'b0;
        hiz_nxt = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (stat_req_nxt && cfg_r[`SS_BRK_ENABLE_BIT] && stat_r) begin
                    st_nxt = ST_BRAKE;
                    ms_nxt = short_ms(cfg_r[`SS_TIME_HI:`SS_TIME_LO]);
                end else if (start_nxt) begin
                    st_nxt = ST_BRAKE;
                    ms_nxt = long_ms(cfg_r[`BRK_HOLD_HI:`BRK_HOLD_LO]);
                end
            end
            ST_BRAKE: begin
                if (brake_done) begin
                    st_nxt = ST_HIZ;
                    ms_nxt = long_ms(cfg_r[`HIZ_HOLD_HI:`HIZ_HOLD_LO]);
                end else if (tk.tick) begin
                    ms_nxt = ms_r - 14'd1;
                end
            end
            ST_HIZ: begin
                if (tk.tick) begin
                    if (ms_r <= 14'd1) begin
                        st_nxt = ST_DONE;
                    end else begin
                        ms_nxt = ms_r - 14'd1;
                    end
                end
            end
            ST_DONE: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
        if (st_nxt == ST_BRAKE) begin
            lo_nxt = !cfg_r[`BRK_SIDE_BIT];
            hi_nxt = cfg_r[`BRK_SIDE_BIT];
        end
        hiz_nxt  = (st_nxt == ST_HIZ);
        busy_nxt = (st_nxt != ST_IDLE);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r  <= ST_IDLE;
            ms_r  <= 14'h0000;
            lo_r  <= 1'b0;
            hi_r  <= 1'b0;
            hiz_r  <= 1'b0;
            busy_r <= 1'b0;
        end else if (ce_i) begin
            st_r   <= st_nxt;
            ms_r   <= ms_nxt;
            lo_r   <= lo_nxt;
            hi_r   <= hi_nxt;
            hiz_r  <= hiz_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign low_side_on_o  = lo_r;
    assign high_side_on_o = hi_r;
    assign outputs_hiz_o  = hiz_r;
    assign busy_o         = busy_r;
endmodule : initial_speed_brake_config
`default_nettype wire

/* File: initial_speed_brake_config_chk.sv */
// Port-level checks for the configuration word and brake sequencer
`timescale 1ns/1ps
`default_nettype none
module initial_speed_brake_config_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // Register bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Levels and power stage
    input wire logic [10:0] phase_emf_mv_i,
    input wire logic [10:0] stat_thr_mv_o,
    input wire logic [10:0] resync_thr_mv_o,
    input wire logic        motor_stationary_o,
    input wire logic        coast_not_resync_o,
    input wire logic        low_side_on_o,
    input wire logic        high_side_on_o,
    input wire logic        outputs_hiz_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_first;
        psel_i && penable_i && ce_i && $rose(penable_i);
    endsequence
    sequence s_unmapped;
        s_first ##0 !(paddr_i inside {12'h200, 12'h084, 12'h088});
    endsequence
    chk_ready_wait: assert property (s_first |=> pready_o ##1 !pready_o)
        else $error("ready not a single pulse after one wait");
    chk_bad_addr: assert property (s_unmapped |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    chk_err_paired: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_rsvd_read: assert property (pready_o && !pwrite_i && paddr_i == 12'h200
        |-> prdata_o[2:0] == 3'h0) else $error("reserved bits not zero");
    chk_side_excl: assert property (!(low_side_on_o && high_side_on_o))
        else $error("both switch sides on");
    chk_hiz_quiet: assert property (outputs_hiz_o |-> !low_side_on_o && !high_side_on_o)
        else $error("switch on during high impedance");
    chk_busy_drive: assert property (low_side_on_o || high_side_on_o || outputs_hiz_o
        |-> busy_o) else $error("stage active while idle");
    chk_stat_level: assert property ((ce_i && $stable(phase_emf_mv_i)
        && $stable(stat_thr_mv_o))[*3] |-> motor_stationary_o
        == (phase_emf_mv_i < stat_thr_mv_o)) else $error("stationary flag wrong");
    chk_coast_level: assert property ((ce_i && $stable(phase_emf_mv_i)
        && $stable(resync_thr_mv_o))[*3] |-> coast_not_resync_o
        == (phase_emf_mv_i < resync_thr_mv_o)) else $error("coast flag wrong");
endmodule : initial_speed_brake_config_chk
bind initial_speed_brake_config initial_speed_brake_config_chk chk_u (.*);
`default_nettype wire

/* File: initial_speed_brake_config_tb_top.sv */
// Register and brake sequence tests for the configuration block
`timescale 1ns/1ps
`default_nettype none
module initial_speed_brake_config_tb_top;
    localparam logic [11:0] CFG = 12'h200;
    localparam logic [11:0] CTL = 12'h084;
    localparam logic [10:0] THR [8] = '{11'h005, 11'h00A, 11'h00F, 11'h014,
                                        11'h019, 11'h01E, 11'h032, 11'h064};
    // Entry 0 is the duty-derived level driven below
    localparam logic [10:0] RES [8] = '{11'h020, 11'h12C, 11'h190, 11'h1F4,
                                        11'h258, 11'h320, 11'h3E8, 11'h4E2};
    logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic        motor_stationary_o, coast_not_resync_o, low_side_on_o;
    logic        high_side_on_o, outputs_hiz_o, busy_o;
    logic        ce_i = 1'b1;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q, w;
    logic [10:0] phase_emf_mv_i, phase_cur_mv_i, stat_thr_mv_o, brk_cur_mv_o;
    logic [10:0] resync_thr_mv_o;
    logic [10:0] min_duty_emf_mv_i = 11'h020;
    int          miscompares, num_checks, cyc, nl, nh, nz;

    initial_speed_brake_config #(.TICK_CYCLES(10)) dut_u (.*);

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Request held until pready is sampled high
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr_en;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // One idle edge so the next setup never re-drives psel in this time step
        @(posedge clk_i);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        check(q, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : rd

    // Counts cycles of each stage until the sequencer is idle again
    task automatic go(input logic [31:0] ctl);
        nl = 0;
        nh = 0;
        nz = 0;
        apb(1'b1, CTL, ctl);
        for (int k = 0; k < 600; k++) begin
            nl += int'(low_side_on_o === 1'b1);
            nh += int'(high_side_on_o === 1'b1);
            nz += int'(outputs_hiz_o === 1'b1);
            if (busy_o !== 1'b1) break;
            @(posedge clk_i);
        end
    endtask : go

    initial begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        phase_emf_mv_i = 11'h02D;
        phase_cur_mv_i = 11'h050;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(CFG, 32'h0, 1'b0);
        rd(12'h0FC, 32'h0, 1'b1);
        apb(1'b1, CFG, 32'hFFFFFFFF);
        rd(CFG, 32'hFFFFFFF8, 1'b0);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            w = (32'(c) << 22) | (32'(c) << 17) | (32'(c) << 3);
            apb(1'b1, CFG, w);
            repeat (3) @(posedge clk_i);
            check(32'(stat_thr_mv_o), 32'(THR[c]));
            check(32'(brk_cur_mv_o), 32'(THR[c]));
            check(32'(resync_thr_mv_o), 32'(RES[c]));
            check(32'(motor_stationary_o), 32'(c > 5));
            check(32'(coast_not_resync_o), 32'(c > 0));
        end
        rd(12'h088, 32'h00000003, 1'b0);
        $display("test decode done");
        apb(1'b1, CFG, 32'h0);
        go(32'h1);
        check(32'(nl > 89 && nl < 103), 32'h1);
        check(32'(nh), 32'h0);
        check(32'(nz > 89 && nz < 103), 32'h1);
        apb(1'b1, CFG, 32'h00200000);
        go(32'h1);
        check(32'(nh > 89 && nh < 103), 32'h1);
        check(32'(nl), 32'h0);
        // 80 mV only exits below the 100 mV level, not the 5 mV default
        apb(1'b1, CFG, 32'h001E0000);
        go(32'h1);
        check(32'(nl > 0 && nl < 20), 32'h1);
        $display("test brake done");
        phase_emf_mv_i <= 11'h000;
        apb(1'b1, CFG, 32'h0);
        go(32'h2);
        check(32'(nl + nz), 32'h0);
        apb(1'b1, CFG, 32'h02000000);
        go(32'h2);
        check(32'(nl > 0 && nl < 13), 32'h1);
        check(32'(nz > 89 && nz < 103), 32'h1);
        $display("test standstill done");
        finish_test();
    end
endmodule : initial_speed_brake_config_tb_top
`default_nettype wire

/* File: isd_cfg.svh */
// Register offsets, field positions and timing counts for the initial speed detect block
`ifndef ISD_CFG_SVH
`define ISD_CFG_SVH

// Register byte offsets; the configuration word is kept as a word index, byte address is 4x
`define CFG_WORD_INDEX          10'h080
`define CFG_WORD_OFFSET         12'h200
`define ISD_CONTROL_OFFSET      12'h084
`define ISD_STATUS_OFFSET       12'h088
`define CFG_WORD_RESET          32'h00000000
`define CFG_WORD_WMASK          32'hFFFFFFF8

// Configuration word field positions
`define SS_BRK_ENABLE_BIT       25
`define STAT_THR_HI             24
`define STAT_THR_LO             22
`define BRK_SIDE_BIT            21
`define BRK_EXIT_BIT            20
`define BRK_CUR_HI              19
`define BRK_CUR_LO              17
`define BRK_HOLD_HI             16
`define BRK_HOLD_LO             13
`define HIZ_HOLD_HI             12
`define HIZ_HOLD_LO             9
`define SS_TIME_HI              8
`define SS_TIME_LO              6
`define RESYNC_HI               5
`define RESYNC_LO               3

// Control register bits
`define CTL_START_BIT           0
`define CTL_STATIONARY_BIT      1

// Timing
`define CLK_PERIOD_NS           10
`define TICK_PERIOD_NS          1000000
`define MS_TICK_CYCLES          (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* File: isd_pkg.sv */
// Types shared by the initial speed detect configuration block
package isd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BRAKE = 2'b01,
        ST_HIZ   = 2'b11,
        ST_DONE  = 2'b10
    } seq_state_e;

    typedef logic [13:0] ms_t;
endpackage : isd_pkg

/* File: isd_tick_gen.sv */
// Millisecond tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "isd_cfg.svh"
module isd_tick_gen #(
    parameter int unsigned TICK_CYCLES = `MS_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    // Tick out
    isd_tick_if.gen    tk
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 32'h00000001;
        if (cnt_r >= TICK_CYCLES - 1) begin
            cnt_nxt  = 32'h00000000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (ce_i) begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule : isd_tick_gen
`default_nettype wire

/* File: isd_tick_if.sv */
// Millisecond tick carrier between the sequencer and the tick generator
`timescale 1ns/1ps
`default_nettype none
interface isd_tick_if;
    logic tick;
    modport gen (output tick);
    modport use_ (input tick);
endinterface : isd_tick_if
`default_nettype wire
